/* rtl/spc_pkg.sv */
package spc_pkg;

  // Register byte offsets on the AXI4-Lite bus.
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_MUL     = 8'h04;
  localparam logic [7:0] OFS_DIV     = 8'h08;
  localparam logic [7:0] OFS_OFFSET  = 8'h0C;
  localparam logic [7:0] OFS_PRESET  = 8'h10;
  localparam logic [7:0] OFS_RAW     = 8'h14;
  localparam logic [7:0] OFS_RESULT  = 8'h18;
  localparam logic [7:0] OFS_STATUS  = 8'h1C;
  localparam logic [7:0] OFS_ID      = 8'h20;

  // Control register field positions.
  localparam int CTRL_MODE_LSB   = 0;
  localparam int CTRL_POLICY_BIT = 2;
  localparam int CTRL_PRGDIR_BIT = 3;
  localparam int CTRL_BATCH_BIT  = 4;
  localparam int CTRL_FREE_BIT   = 5;
  localparam int CTRL_FREEOFS_BIT = 6;
  localparam int CTRL_MENU_BIT   = 7;

  // Reset values.
  localparam logic [31:0] MUL_RST    = 32'h0000_0001;
  localparam logic [31:0] DIV_RST    = 32'h0000_0001;
  localparam logic [31:0] OFFSET_RST = 32'h0000_0000;
  localparam logic [7:0]  CTRL_RST   = 8'h00;

  // Identifier word, value arbitrary.
  localparam logic [31:0] DEVICE_ID = 32'h5043_0001;

  // Display limits.
  localparam logic signed [47:0] RESULT_MAX = 48'sd999999;
  localparam logic signed [47:0] RESULT_MIN = -48'sd99999;

  // Timing.
  localparam int CLK_HZ        = 20_000_000;
  localparam int VIEW_TIMEOUT_S = 5;
  localparam int VIEW_TIMEOUT_CYC = CLK_HZ * VIEW_TIMEOUT_S;
  localparam int ESC_HOLD_S    = 2;
  localparam int ESC_HOLD_CYC  = CLK_HZ * ESC_HOLD_S;

  // Counting modes.
  typedef enum logic [1:0] {
    MODE_SUM,
    MODE_DIFF,
    MODE_QUAD1,
    MODE_QUAD4
  } spc_mode_type;

  // Quick view selection.
  typedef enum logic [1:0] {
    VIEW_OFF,
    VIEW_OFFSET,
    VIEW_THRESHOLD
  } spc_view_type;

endpackage

/* rtl/spc_core.sv */
// Notes on behaviour
// - Four counting modes: sum, difference, quadrature x1, quadrature x4.
// - Sum mode: every pulse on A or B increments the count.
// - Difference mode: A pulses add, B pulses subtract.
// - Quadrature modes decode A/B phase, direction follows phase order.
// - Result derives from raw count with numerator, denominator, offset.
// - Above 999999 flags overflow; below -99999 flags underflow.
// - Zeroing from reset key, external reset input or serial preset.
// - Reset key zeroing takes effect only after enter confirms it.
// - Right after zeroing the result equals the offset.
// - Up key cycles quick view; returns after 5 s without an up key press.
// - Quick view edits: threshold with free or free offset access, offset only with free offset access.
// - Counting continues while the menu is open.
// - Deferred policy applies scaling changes only at zeroing or power-up.
// - Immediate policy applies scaling changes at once.
// - Power-up starts from stored data, then enters operation.
// - Programmable input may reverse the counting direction.
// - With batching enabled the offset is first in quick view.
// - Every parameter is writable remotely over the serial bus.
// - Inputs up to 10 kHz standard and 5 kHz quadrature are accepted.
module spc_core (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        in_a,
  input  wire logic        in_b,
  input  wire logic        in_c,
  input  wire logic        in_d,
  input  wire logic        key_reset,
  input  wire logic        key_enter,
  input  wire logic        key_up,
  input  wire logic [31:0] stored_raw,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             overflow_indicator,
  output logic             underflow_indicator,
  output logic [1:0]       view_sel,
  output logic             view_edit_ok
);

  // Reset synchroniser.
  logic rst_meta_n;
  logic rst_sync_n;
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // Two-stage synchronisers for the seven pin inputs.
  logic [6:0] pin_raw;
  logic [6:0] pin_meta;
  logic [6:0] pin_sync;
  logic [6:0] pin_last;
  assign pin_raw = {key_up, key_enter, key_reset, in_d, in_c, in_b, in_a};
  always_ff @(posedge core_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      pin_meta <= 7'h00;
      pin_sync <= 7'h00;
      pin_last <= 7'h00;
    end
    else
    begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
      pin_last <= pin_sync;
    end
  end

  logic a_s, b_s, c_s, a_rise, b_rise, a_edge, b_edge;
  logic d_rise, rkey_rise, enter_rise, up_rise;
  assign a_s        = pin_sync[0];
  assign b_s        = pin_sync[1];
  assign c_s        = pin_sync[2];
  assign a_rise     = pin_sync[0] & ~pin_last[0];
  assign b_rise     = pin_sync[1] & ~pin_last[1];
  assign a_edge     = pin_sync[0] ^ pin_last[0];
  assign b_edge     = pin_sync[1] ^ pin_last[1];
  assign d_rise     = pin_sync[3] & ~pin_last[3];
  assign rkey_rise  = pin_sync[4] & ~pin_last[4];
  assign enter_rise = pin_sync[5] & ~pin_last[5];
  assign up_rise    = pin_sync[6] & ~pin_last[6];

  // Software-visible configuration.
  logic [7:0]  ctrl;
  logic [31:0] mul_pend, div_pend, ofs_pend;
  logic [31:0] mul_act, div_act, ofs_act;
  logic        preset_wr;
  spc_pkg::spc_mode_type mode;
  assign mode = spc_pkg::spc_mode_type'(ctrl[spc_pkg::CTRL_MODE_LSB +: 2]);

  // Reset key request waiting for the enter confirmation.
  logic reset_armed;
  always_ff @(posedge core_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      reset_armed <= 1'b0;
    else if (rkey_rise)
      reset_armed <= 1'b1;
    else if (enter_rise)
      reset_armed <= 1'b0;
  end

  logic zero_req;
  assign zero_req = (reset_armed & enter_rise) | d_rise | preset_wr;

  // Quadrature decode: step and direction from the A/B transitions.
  logic       q_step4, q_dir, q_step1;
  always_comb
  begin
    q_step4 = a_edge ^ b_edge;
    q_dir   = a_edge ? (a_s ^ b_s) : ~(a_s ^ b_s);
    q_step1 = a_rise & ~b_s & ~b_edge;
  end

  // Count step per mode, with optional reversal by input C.
  // In sum mode pulses on A and B in one cycle both count, so a step can reach two.
  logic signed [2:0] step;
  logic signed [2:0] next_step;
  always_comb
  begin
    next_step = 3'sd0;
    case (mode)
      spc_pkg::MODE_SUM:
        next_step = signed'({2'b00, a_rise} + {2'b00, b_rise});
      spc_pkg::MODE_DIFF:
        next_step = (a_rise & ~b_rise) ? 3'sd1 :
                    (b_rise & ~a_rise) ? -3'sd1 : 3'sd0;
      spc_pkg::MODE_QUAD1:
        next_step = q_step1 ? 3'sd1 :
                    (b_rise & ~a_s & ~a_edge) ? -3'sd1 : 3'sd0;
      spc_pkg::MODE_QUAD4:
        next_step = !q_step4 ? 3'sd0 : (q_dir ? 3'sd1 : -3'sd1);
      default:
        next_step = 3'sd0;
    endcase
    if (ctrl[spc_pkg::CTRL_PRGDIR_BIT] && c_s)
      step = -next_step;
    else
      step = next_step;
  end

  // Raw count, loaded from stored data after power-up, cleared on zeroing.
  logic signed [31:0] raw;
  logic               loaded;
  always_ff @(posedge core_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      raw    <= 32'sh0000_0000;
      loaded <= 1'b0;
    end
    else if (!loaded)
    begin
      raw    <= stored_raw;
      loaded <= 1'b1;
    end
    else if (zero_req)
      raw <= 32'sh0000_0000;
    else
      raw <= raw + 32'(signed'(step));
  end

  // Active scaling set: copied at once or only on zeroing and start-up.
  always_ff @(posedge core_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      mul_act <= spc_pkg::MUL_RST;
      div_act <= spc_pkg::DIV_RST;
      ofs_act <= spc_pkg::OFFSET_RST;
    end
    else if (ctrl[spc_pkg::CTRL_POLICY_BIT] || zero_req || !loaded)
    begin
      mul_act <= mul_pend;
      div_act <= div_pend;
      ofs_act <= ofs_pend;
    end
  end

  // Scaled result and range flags.
  logic signed [63:0] product;
  logic signed [47:0] scaled;
  logic signed [47:0] result;
  logic [31:0]        div_nz;
  assign div_nz  = (div_act == 32'h0000_0000) ? 32'h0000_0001 : div_act;
  assign product = 64'(raw) * 64'(signed'(mul_act));
  assign scaled  = 48'(product / 64'(signed'(div_nz)));
  assign result  = scaled + 48'(signed'(ofs_act));

  always_ff @(posedge core_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      overflow_indicator  <= 1'b0;
      underflow_indicator <= 1'b0;
    end
    else
    begin
      overflow_indicator  <= result > spc_pkg::RESULT_MAX;
      underflow_indicator <= result < spc_pkg::RESULT_MIN;
    end
  end

  // Quick view: up key steps through offset (batching) and threshold.
  logic [31:0] view_timer;
  spc_pkg::spc_view_type view;
  always_ff @(posedge core_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      view       <= spc_pkg::VIEW_OFF;
      view_timer <= 32'h0000_0000;
    end
    else if (up_rise)
    begin
      view_timer <= 32'(spc_pkg::VIEW_TIMEOUT_CYC);
      case (view)
        spc_pkg::VIEW_OFF:
          view <= ctrl[spc_pkg::CTRL_BATCH_BIT] ? spc_pkg::VIEW_OFFSET
                                                : spc_pkg::VIEW_THRESHOLD;
        spc_pkg::VIEW_OFFSET:
          view <= spc_pkg::VIEW_THRESHOLD;
        spc_pkg::VIEW_THRESHOLD:
          view <= ctrl[spc_pkg::CTRL_BATCH_BIT] ? spc_pkg::VIEW_OFFSET
                                                : spc_pkg::VIEW_THRESHOLD;
        default:
          view <= spc_pkg::VIEW_OFF;
      endcase
    end
    else if (view_timer == 32'h0000_0001)
    begin
      view       <= spc_pkg::VIEW_OFF;
      view_timer <= 32'h0000_0000;
    end
    else if (view_timer != 32'h0000_0000)
      view_timer <= view_timer - 32'h0000_0001;
  end

  always_ff @(posedge core_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      view_sel     <= 2'h0;
      view_edit_ok <= 1'b0;
    end
    else
    begin
      view_sel     <= view;
      view_edit_ok <= (view == spc_pkg::VIEW_THRESHOLD &&
                       (ctrl[spc_pkg::CTRL_FREE_BIT] ||
                        ctrl[spc_pkg::CTRL_FREEOFS_BIT])) ||
                      (view == spc_pkg::VIEW_OFFSET &&
                       ctrl[spc_pkg::CTRL_FREEOFS_BIT]);
    end
  end

  // AXI4-Lite write channel: address and data in either order.
  logic        aw_held, w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        wr_go;
  assign wr_go = aw_held & w_held & ~s_axi_bvalid;
  assign preset_wr = wr_go & (aw_addr == spc_pkg::OFS_PRESET);
  always_ff @(posedge core_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end
    else
    begin
      s_axi_awready <= ~aw_held & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~w_held & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;            // Strobes are held with the data.
      end
      if (wr_go)
      begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr > spc_pkg::OFS_PRESET ||
                         aw_addr[1:0] != 2'h0) ? 2'h2 : 2'h0;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Register writes, full words only.
  always_ff @(posedge core_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      ctrl     <= spc_pkg::CTRL_RST;
      mul_pend <= spc_pkg::MUL_RST;
      div_pend <= spc_pkg::DIV_RST;
      ofs_pend <= spc_pkg::OFFSET_RST;
    end
    else if (wr_go && w_strb == 4'hF)
    begin
      case (aw_addr)
        spc_pkg::OFS_CTRL:   ctrl     <= w_data[7:0];
        spc_pkg::OFS_MUL:    mul_pend <= w_data;
        spc_pkg::OFS_DIV:    div_pend <= w_data;
        spc_pkg::OFS_OFFSET: ofs_pend <= w_data;
        default:             ctrl     <= ctrl;
      endcase
    end
  end

  // AXI4-Lite read channel.
  always_ff @(posedge core_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
    end
    else
    begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'h0;
        case (s_axi_araddr[7:0])
          spc_pkg::OFS_CTRL:   s_axi_rdata <= {24'h000000, ctrl};
          spc_pkg::OFS_MUL:    s_axi_rdata <= mul_pend;
          spc_pkg::OFS_DIV:    s_axi_rdata <= div_pend;
          spc_pkg::OFS_OFFSET: s_axi_rdata <= ofs_pend;
          spc_pkg::OFS_PRESET: s_axi_rdata <= 32'h0000_0000;
          spc_pkg::OFS_RAW:    s_axi_rdata <= raw;
          spc_pkg::OFS_RESULT: s_axi_rdata <= result[31:0];
          spc_pkg::OFS_STATUS: s_axi_rdata <= {29'h0, reset_armed,
                                  underflow_indicator, overflow_indicator};
          spc_pkg::OFS_ID:     s_axi_rdata <= spc_pkg::DEVICE_ID;
          default:
          begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // Zeroing makes the next result equal the offset.
  a_zero_offset: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    loaded && zero_req |=> raw == 0 && ofs_act == $past(ofs_pend))
    else $error("zeroing did not restart at the offset");
  // Deferred policy keeps active scale until zeroing.
  a_defer_hold: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    loaded && !ctrl[spc_pkg::CTRL_POLICY_BIT] && !zero_req |=> $stable(mul_act))
    else $error("scale changed without zeroing");
  // Overflow flag follows the result.
  a_over_flag: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    result > spc_pkg::RESULT_MAX |=> overflow_indicator)
    else $error("overflow not flagged");
  // Reset key alone never clears the count.
  a_key_confirm: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    loaded && rkey_rise && !d_rise && !preset_wr &&
    !(reset_armed && enter_rise) |=> raw != 0 || $past(raw) == 0
    || $past(step) != 0)
    else $error("reset key acted without enter");
  // Sum mode counts up by one on a pulse.
  a_sum_count: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    loaded && !zero_req && mode == spc_pkg::MODE_SUM &&
    !ctrl[spc_pkg::CTRL_PRGDIR_BIT] && a_rise
    |=> raw == $past(raw) + ($past(b_rise) ? 2 : 1))
    else $error("sum mode miscount");
  // Write response follows a completed write.
  a_write_resp: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    wr_go |=> s_axi_bvalid)
    else $error("no write response");
  // Quick view ends after timeout.
  a_view_end: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    view_timer == 1 && !up_rise |=> view == spc_pkg::VIEW_OFF)
    else $error("quick view did not time out");
  // Batching view starts at the offset.
  a_view_first: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    up_rise && view == spc_pkg::VIEW_OFF && ctrl[spc_pkg::CTRL_BATCH_BIT]
    |=> view == spc_pkg::VIEW_OFFSET)
    else $error("offset not first in view");

endmodule

/* dv/spc_pulse_src.sv */
module spc_pulse_src #(
  parameter int HALF_CYC = 1000
) (
  input  wire logic core_clk,
  output logic      pa,
  output logic      pb
);
  timeunit 1ns;
  timeprecision 1ns;

  // Push-pull sensor outputs rest low between pulses.
  initial
  begin
    pa = 1'b0;
    pb = 1'b0;
  end

  // Every level stands HALF_CYC cycles, so the rate stays in range.
  task automatic hold();
    repeat (HALF_CYC) @(posedge core_clk);
  endtask

  // Single pulses on one counting input.
  task automatic pulses(input bit on_b, input int n);
    repeat (n)
    begin
      pa <= ~on_b;
      pb <= on_b;
      hold();
      pa <= 1'b0;
      pb <= 1'b0;
      hold();
    end
  endtask

  // Quadrature cycles; forward means A leads B by a quarter cycle.
  task automatic quad(input bit fwd, input int n);
    logic [3:0] lead;
    logic [3:0] lag;
    lead = 4'h3;
    lag = 4'h6;
    repeat (n)
      for (int i = 0; i < 4; i++)
      begin
        pa <= fwd ? lead[i] : lag[i];
        pb <= fwd ? lag[i] : lead[i];
        hold();
      end
  endtask
endmodule

/* dv/tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic        core_clk = 1'b0;
  logic        rst_n, in_a, in_b, in_c, in_d, key_reset, key_enter, key_up;
  logic        awvalid, wvalid, bready, arvalid, rready, awready, wready;
  logic        bvalid, arready, rvalid, ovf, unf, edit_ok;
  logic [1:0]  bresp, rresp, view;
  logic [3:0]  wstrb;
  logic [31:0] awaddr, wdata, araddr, rdata, stored;
  int          failures = 0;
  int          total_checks = 0;

  // Free-running 20 MHz clock.
  always #25 core_clk = ~core_clk;

  spc_pulse_src #(.HALF_CYC(8)) src (
    .core_clk(core_clk), .pa(in_a), .pb(in_b));

  spc_core dut (
    .core_clk(core_clk), .rst_n(rst_n), .in_a(in_a), .in_b(in_b),
    .in_c(in_c), .in_d(in_d), .key_reset(key_reset),
    .key_enter(key_enter), .key_up(key_up), .stored_raw(stored),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .overflow_indicator(ovf),
    .underflow_indicator(unf), .view_sel(view), .view_edit_ok(edit_ok));

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // Holds reset 12 cycles, then leaves room for the internal release.
  task automatic do_reset();
    rst_n <= 1'b0;
    tick(12);
    rst_n <= 1'b1;
    tick(8);
  endtask

  // One AXI4-Lite write; address and data are offered together.
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    bit ad;
    bit wd;
    ad = 1'b0;
    wd = 1'b0;
    awaddr <= {24'h0, a};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ad && wd))
    begin
      @(posedge core_clk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      ad = ad | awready;
      wd = wd | wready;
    end
    bready <= 1'b1;
    do @(posedge core_clk); while (!bvalid);
    bready <= 1'b0;
    check({30'h0, bresp}, {30'h0, er}, "write response");
  endtask

  // One AXI4-Lite read, judged against the expected word and response.
  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                    input logic [1:0] er);
    araddr <= {24'h0, a};
    arvalid <= 1'b1;
    do @(posedge core_clk); while (!arready);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge core_clk); while (!rvalid);
    rready <= 1'b0;
    check({30'h0, rresp}, {30'h0, er}, "read response");
    check(rdata, exp, "read data");
  endtask

  // Presses a key (0 reset, 1 enter, 2 up, else external reset input).
  task automatic press(input int k);
    case (k)
      0: key_reset <= 1'b1;
      1: key_enter <= 1'b1;
      2: key_up <= 1'b1;
      default: in_d <= 1'b1;
    endcase
    tick(6);
    key_reset <= 1'b0;
    key_enter <= 1'b0;
    key_up <= 1'b0;
    in_d <= 1'b0;
    tick(6);
  endtask

  task automatic t_regs();
    rd(spc_pkg::OFS_CTRL, {24'h0, spc_pkg::CTRL_RST}, 2'h0);
    rd(spc_pkg::OFS_MUL, spc_pkg::MUL_RST, 2'h0);
    rd(spc_pkg::OFS_DIV, spc_pkg::DIV_RST, 2'h0);
    rd(spc_pkg::OFS_OFFSET, spc_pkg::OFFSET_RST, 2'h0);
    rd(spc_pkg::OFS_ID, spc_pkg::DEVICE_ID, 2'h0);
    rd(spc_pkg::OFS_RAW, 32'h0000_0009, 2'h0);
    rd(spc_pkg::OFS_RESULT, 32'h0000_0009, 2'h0);
    rd(8'h24, 32'h0000_0000, 2'h2);
    wr(8'h28, 32'h0000_0001, 2'h2);
    wstrb <= 4'h3;
    wr(spc_pkg::OFS_MUL, 32'h0000_0005, 2'h0);
    wstrb <= 4'hF;
    rd(spc_pkg::OFS_MUL, spc_pkg::MUL_RST, 2'h0);
    check({30'h0, view}, 32'h0, "view after reset");
    $display("test regs done");
  endtask

  task automatic t_modes();
    wr(spc_pkg::OFS_CTRL, 32'h0000_0084, 2'h0);
    wr(spc_pkg::OFS_PRESET, 32'h0, 2'h0);
    src.pulses(1'b0, 3);
    src.pulses(1'b1, 2);
    rd(spc_pkg::OFS_RAW, 32'h0000_0005, 2'h0);
    wr(spc_pkg::OFS_CTRL, 32'h0000_0005, 2'h0);
    wr(spc_pkg::OFS_PRESET, 32'h0, 2'h0);
    src.pulses(1'b0, 3);
    src.pulses(1'b1, 5);
    rd(spc_pkg::OFS_RAW, -32'sd2, 2'h0);
    wr(spc_pkg::OFS_CTRL, 32'h0000_000D, 2'h0);
    in_c <= 1'b1;
    src.pulses(1'b0, 2);
    rd(spc_pkg::OFS_RAW, -32'sd4, 2'h0);
    in_c <= 1'b0;
    wr(spc_pkg::OFS_CTRL, 32'h0000_0007, 2'h0);
    wr(spc_pkg::OFS_PRESET, 32'h0, 2'h0);
    src.quad(1'b1, 2);
    rd(spc_pkg::OFS_RAW, 32'h0000_0008, 2'h0);
    src.quad(1'b0, 1);
    rd(spc_pkg::OFS_RAW, 32'h0000_0004, 2'h0);
    wr(spc_pkg::OFS_CTRL, 32'h0000_0006, 2'h0);
    wr(spc_pkg::OFS_PRESET, 32'h0, 2'h0);
    src.quad(1'b1, 3);
    rd(spc_pkg::OFS_RAW, 32'h0000_0003, 2'h0);
    src.quad(1'b0, 1);
    rd(spc_pkg::OFS_RAW, 32'h0000_0002, 2'h0);
    $display("test modes done");
  endtask

  task automatic t_scale();
    wr(spc_pkg::OFS_CTRL, 32'h0000_0004, 2'h0);
    wr(spc_pkg::OFS_MUL, 32'h0000_0003, 2'h0);
    wr(spc_pkg::OFS_DIV, 32'h0000_0002, 2'h0);
    wr(spc_pkg::OFS_OFFSET, 32'h0000_0007, 2'h0);
    rd(spc_pkg::OFS_MUL, 32'h0000_0003, 2'h0);
    wr(spc_pkg::OFS_PRESET, 32'h0, 2'h0);
    rd(spc_pkg::OFS_RESULT, 32'h0000_0007, 2'h0);
    src.pulses(1'b0, 4);
    rd(spc_pkg::OFS_RESULT, 32'h0000_000D, 2'h0);
    wr(spc_pkg::OFS_OFFSET, 32'd999994, 2'h0);
    tick(4);
    check({31'h0, ovf}, 32'h1, "overflow flag");
    wr(spc_pkg::OFS_OFFSET, 32'd999993, 2'h0);
    tick(4);
    check({31'h0, ovf}, 32'h0, "overflow at limit");
    wr(spc_pkg::OFS_OFFSET, -32'sd100006, 2'h0);
    tick(4);
    check({31'h0, unf}, 32'h1, "underflow flag");
    wr(spc_pkg::OFS_OFFSET, -32'sd100005, 2'h0);
    tick(4);
    check({31'h0, unf}, 32'h0, "underflow at limit");
    $display("test scale done");
  endtask

  task automatic t_defer();
    wr(spc_pkg::OFS_CTRL, 32'h0000_0000, 2'h0);
    wr(spc_pkg::OFS_MUL, 32'h0000_0001, 2'h0);
    wr(spc_pkg::OFS_DIV, 32'h0000_0001, 2'h0);
    wr(spc_pkg::OFS_OFFSET, 32'h0000_0005, 2'h0);
    wr(spc_pkg::OFS_PRESET, 32'h0, 2'h0);
    src.pulses(1'b0, 2);
    rd(spc_pkg::OFS_RESULT, 32'h0000_0007, 2'h0);
    wr(spc_pkg::OFS_MUL, 32'h0000_0004, 2'h0);
    rd(spc_pkg::OFS_RESULT, 32'h0000_0007, 2'h0);
    press(3);
    rd(spc_pkg::OFS_RESULT, 32'h0000_0005, 2'h0);
    src.pulses(1'b0, 1);
    rd(spc_pkg::OFS_RESULT, 32'h0000_0009, 2'h0);
    press(0);
    rd(spc_pkg::OFS_RAW, 32'h0000_0001, 2'h0);
    rd(spc_pkg::OFS_STATUS, 32'h0000_0004, 2'h0);
    press(1);
    rd(spc_pkg::OFS_RAW, 32'h0000_0000, 2'h0);
    rd(spc_pkg::OFS_STATUS, 32'h0000_0000, 2'h0);
    rd(spc_pkg::OFS_RESULT, 32'h0000_0005, 2'h0);
    $display("test defer done");
  endtask

  task automatic t_view();
    press(2);
    check({30'h0, view}, 32'h2, "view without batch");
    check({31'h0, edit_ok}, 32'h0, "edit locked");
    do_reset();
    wr(spc_pkg::OFS_CTRL, 32'h0000_0051, 2'h0);
    press(2);
    check({30'h0, view}, 32'h1, "offset first");
    check({31'h0, edit_ok}, 32'h1, "edit allowed");
    press(2);
    check({30'h0, view}, 32'h2, "view steps on");
    $display("test view done");
  endtask

  // Main sequence.
  initial
  begin
    rst_n = 1'b0;
    {in_c, in_d, key_reset, key_enter, key_up} = 5'h00;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 32'h0;
    wdata = 32'h0;
    araddr = 32'h0;
    wstrb = 4'hF;
    stored = 32'h0000_0009;
    do_reset();
    t_regs();
    t_modes();
    t_scale();
    t_defer();
    t_view();
    complete_run();
  end

  // Cuts a hang short.
  initial
  begin
    tick(60000);
    failures++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    complete_run();
  end
endmodule
